/* File: rtl/utm_map.vh */
// Overview of operation
// R1: single-pulse mode sends alternating +3/-3 isolated pulses, 1.5 ms apart.
// R2: single-pulse mode by straps reset=1,test=1 or C/I 0101, identical behaviour.
// R3: single-pulse mode reports deactivate in line-terminal, deactivation request otherwise.
// R4: data-through forces the activation machine straight into transparent from anywhere.
// R5: data-through sends normal scrambled signal with no wake-up handshake.
// R6: data-through by straps reset=0,test=1 or C/I code 0110.
// R7: with data-through held by straps, C/I commands such as loop-back still act.
// R8: master-reset: Test state, transmitter off, all coefficients cleared.
// R9: in Test state no activation procedure may start.
// R10: master-reset by straps reset=0,test=0 or C/I reset code 0001.
// R11: Test state reports deactivate in line-terminal, deactivation request otherwise.
// R12: line-terminal also enters Test on power status pin 1 or C/I 0011.
// R13: pin cause reports power fault; code 0011 reports deactivate, asserts supply disable.
// R14: network-terminal answers monitor self-test request with self-test passed.
// R15: register read request is two bytes: access marker, then register address.
// R16: selected 16-bit value is returned as two two-byte messages.
// R17: every internal command reply starts with byte 80 hex.
// R18: strap pins sampled on the clock, mode applied within a few cycles.
`ifndef UTM_MAP_VH
`define UTM_MAP_VH
// ***********************************
// timing
// ***********************************
`define UTM_CLK_MHZ 25
`define UTM_CLK_NS 40
`define UTM_PULSE_GAP_US 1500
`define UTM_PULSE_GAP_CYC (`UTM_PULSE_GAP_US * `UTM_CLK_MHZ)
`define UTM_SYMBOL_NS 12500
`define UTM_SYMBOL_CYC (`UTM_SYMBOL_NS / `UTM_CLK_NS)
// ***********************************
// c/i codes
// ***********************************
`define UTM_CI_RES 4'h1
`define UTM_CI_LTD 4'h3
`define UTM_CI_SSP 4'h5
`define UTM_CI_DT 4'h6
`define UTM_CI_ARL 4'h8
`define UTM_CI_DEACTIVATE_INDICATION 4'hf
`define UTM_CI_DR 4'h0
`define UTM_CI_HI 4'hc
// ***********************************
// monitor messages
// ***********************************
`define UTM_MON1_HDR 8'h10
`define UTM_MON_ST 8'h02
`define UTM_MON_STP 8'h03
`define UTM_MON8_REG 8'h88
`define UTM_MON8_REPLY 8'h80
`endif

/* File: rtl/utm_pulse.v */
`timescale 1ns/1ns
`include "utm_map.vh"
// ***********************************
// isolated alternating pulse generator
// ***********************************
module utm_pulse #(
	parameter GAP_CYC = `UTM_PULSE_GAP_CYC,
	parameter WIDTH_CYC = `UTM_SYMBOL_CYC
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// control
	input wire enable,
	// pulse drive
	output reg pulse_pos_ff,
	output reg pulse_neg_ff
);
	reg [31:0] cnt_ff;
	reg polarity_ff;
	wire [31:0] nxt_cnt;
	wire at_gap;

	// gap timer; restarts on every enable so the first pulse is immediate
	assign at_gap = (cnt_ff == GAP_CYC - 1);
	assign nxt_cnt = (!enable || at_gap) ? 32'h0 : cnt_ff + 32'h1;

	// pulse one symbol long at the start of each gap, sign flips each time
	always @(posedge clk) begin
		if (!reset_n) begin
			cnt_ff <= 32'h0;
			polarity_ff <= 1'b0;
			pulse_pos_ff <= 1'b0;
			pulse_neg_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			if (enable && at_gap)
				polarity_ff <= ~polarity_ff; // R1
			pulse_pos_ff <= enable && (cnt_ff < WIDTH_CYC) && !polarity_ff; // R1
			pulse_neg_ff <= enable && (cnt_ff < WIDTH_CYC) && polarity_ff; // R1
		end
	end
endmodule

/* File: rtl/utm_ctrl.v */
`timescale 1ns/1ns
`include "utm_map.vh"
// ***********************************
// test mode and monitor control
// ***********************************
module utm_ctrl #(
	parameter PULSE_GAP_CYC = `UTM_PULSE_GAP_CYC
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// straps and configuration
	input wire master_reset_pin_n,
	input wire test_select_pin,
	input wire power_status_pin,
	input wire lt_mode,
	// c/i channel
	input wire ci_rx_valid,
	input wire [3:0] ci_rx_code,
	input wire [3:0] act_ind_code,
	output reg [3:0] ci_tx_code_ff,
	// activation machine and line control
	output reg force_transparent_ff,
	output reg activation_inhibit_ff,
	output reg tx_enable_ff,
	output reg tx_scrambled_ff,
	output reg coef_clear_ff,
	output reg analog_loopback_ff,
	output reg supply_disable_output_ff,
	output wire pulse_pos_ff,
	output wire pulse_neg_ff,
	// monitor receive
	input wire mon_rx_valid,
	input wire [7:0] mon_rx_byte0,
	input wire [7:0] mon_rx_byte1,
	output reg mon_rx_ready_ff,
	// monitor transmit
	output reg mon_tx_valid_ff,
	output reg [7:0] mon_tx_byte0_ff,
	output reg [7:0] mon_tx_byte1_ff,
	input wire mon_tx_ready,
	// internal register port
	output reg [7:0] coef_addr_ff,
	input wire [15:0] coef_rd_data
);
	// mode states
	localparam [3:0] ST_NORM = 4'b0001;
	localparam [3:0] ST_SSP = 4'b0010;
	localparam [3:0] ST_DT = 4'b0100;
	localparam [3:0] ST_TEST = 4'b1000;
	// monitor states
	localparam [4:0] M_IDLE = 5'b00001;
	localparam [4:0] M_STP = 5'b00010;
	localparam [4:0] M_RD = 5'b00100;
	localparam [4:0] M_HI = 5'b01000;
	localparam [4:0] M_LO = 5'b10000;

	reg [1:0] strap_ff;
	reg [1:0] strap_hold_ff;
	reg ps_ff;
	reg [3:0] sw_mode_ff;
	reg [3:0] nxt_sw_mode;
	reg sw_ltd_ff;
	reg nxt_sw_ltd;
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg ps_cause;
	reg ltd_cause;
	reg [3:0] nxt_ci;
	reg [4:0] mstate_ff;
	reg [4:0] nxt_mstate;
	reg [15:0] rd_val_ff;
	wire hw_norm;
	wire mon_take;
	wire ci_stop;

	// ***********************************
	// strap sampling
	// ***********************************
	// two stages: a strap change must persist one extra cycle before it counts,
	// which keeps a bouncing jumper from flicking the line in and out of test
	always @(posedge clk) begin
		if (!reset_n) begin
			strap_ff <= 2'b10;
			strap_hold_ff <= 2'b10;
			ps_ff <= 1'b0;
		end else begin
			strap_ff <= {master_reset_pin_n, test_select_pin}; // R18
			if (strap_ff == {master_reset_pin_n, test_select_pin})
				strap_hold_ff <= strap_ff; // R18
			ps_ff <= power_status_pin;
		end
	end

	// reset=1, test=0 leaves the choice to software
	assign hw_norm = (strap_hold_ff == 2'b10);

	// ***********************************
	// software mode from c/i commands
	// ***********************************
	always @* begin
		nxt_sw_mode = sw_mode_ff;
		nxt_sw_ltd = sw_ltd_ff;
		if (ci_rx_valid) begin
			case (ci_rx_code)
				`UTM_CI_SSP: begin
					nxt_sw_mode = ST_SSP; // R2
					nxt_sw_ltd = 1'b0;
				end
				`UTM_CI_DT: begin
					nxt_sw_mode = ST_DT; // R6
					nxt_sw_ltd = 1'b0;
				end
				`UTM_CI_RES: begin
					nxt_sw_mode = ST_TEST; // R10
					nxt_sw_ltd = 1'b0;
				end
				`UTM_CI_LTD: begin
					// power-down request only counts on the line-terminal side
					if (lt_mode) begin
						nxt_sw_mode = ST_TEST; // R12
						nxt_sw_ltd = 1'b1;
					end
				end
				`UTM_CI_ARL: begin
					nxt_sw_mode = sw_mode_ff;
				end
				default: begin
					nxt_sw_mode = ST_NORM;
					nxt_sw_ltd = 1'b0;
				end
			endcase
		end
	end

	// ***********************************
	// mode selection, straps win over software
	// ***********************************
	always @* begin
		ps_cause = 1'b0;
		ltd_cause = 1'b0;
		case (strap_hold_ff)
			2'b11: nxt_state = ST_SSP; // R2
			2'b01: nxt_state = ST_DT; // R6
			2'b00: nxt_state = ST_TEST; // R10
			default: begin
				if (lt_mode && ps_ff) begin
					nxt_state = ST_TEST; // R12
					ps_cause = 1'b1;
				end else begin
					nxt_state = sw_mode_ff;
					ltd_cause = sw_ltd_ff;
				end
			end
		endcase
	end

	// ***********************************
	// c/i indication per mode
	// ***********************************
	always @* begin
		case (nxt_state)
			ST_SSP: nxt_ci = lt_mode ? `UTM_CI_DEACTIVATE_INDICATION : `UTM_CI_DR; // R3
			ST_TEST: begin
				if (!lt_mode)
					nxt_ci = `UTM_CI_DR; // R11
				else if (ps_cause)
					nxt_ci = `UTM_CI_HI; // R13
				else
					nxt_ci = `UTM_CI_DEACTIVATE_INDICATION; // R11
			end
			default: nxt_ci = act_ind_code;
		endcase
	end

	// reset code opens the loop and stops pending loop-back
	assign ci_stop = ci_rx_valid && (ci_rx_code == `UTM_CI_RES);

	// ***********************************
	// mode registers and line controls
	// ***********************************
	always @(posedge clk) begin
		if (!reset_n) begin
			sw_mode_ff <= ST_NORM;
			sw_ltd_ff <= 1'b0;
			state_ff <= ST_NORM;
			ci_tx_code_ff <= `UTM_CI_DR;
			force_transparent_ff <= 1'b0;
			activation_inhibit_ff <= 1'b0;
			tx_enable_ff <= 1'b0;
			tx_scrambled_ff <= 1'b0;
			coef_clear_ff <= 1'b0;
			analog_loopback_ff <= 1'b0;
			supply_disable_output_ff <= 1'b0;
		end else begin
			sw_mode_ff <= nxt_sw_mode;
			sw_ltd_ff <= nxt_sw_ltd;
			state_ff <= nxt_state;
			ci_tx_code_ff <= nxt_ci;
			// c/i commands still decoded with straps holding the mode
			if (ci_stop)
				analog_loopback_ff <= 1'b0;
			else if (ci_rx_valid && ci_rx_code == `UTM_CI_ARL)
				analog_loopback_ff <= 1'b1; // R7
			force_transparent_ff <= (nxt_state == ST_DT); // R4
			tx_scrambled_ff <= (nxt_state == ST_DT); // R5
			// activation machine held off; data-through skips the wake-up too
			activation_inhibit_ff <= (nxt_state != ST_NORM); // R9 R5
			tx_enable_ff <= (nxt_state == ST_NORM) || (nxt_state == ST_DT); // R8
			coef_clear_ff <= (nxt_state == ST_TEST); // R8
			supply_disable_output_ff <= (nxt_state == ST_TEST) && ltd_cause; // R13
		end
	end

	// ***********************************
	// single pulse generator
	// ***********************************
	// enable from the next state so pulses stop on the same edge as the mode
	utm_pulse #(
		.GAP_CYC(PULSE_GAP_CYC),
		.WIDTH_CYC(`UTM_SYMBOL_CYC)
	) u_pulse (
		.clk(clk),
		.reset_n(reset_n),
		.enable(nxt_state == ST_SSP), // R1
		.pulse_pos_ff(pulse_pos_ff),
		.pulse_neg_ff(pulse_neg_ff)
	);

	// ***********************************
	// monitor message handling
	// ***********************************
	// one message at a time; a new request waits until the reply is taken
	assign mon_take = mon_rx_valid && mon_rx_ready_ff;

	always @* begin
		nxt_mstate = mstate_ff;
		case (mstate_ff)
			M_IDLE: begin
				if (mon_take) begin
					if (mon_rx_byte0 == `UTM_MON1_HDR && mon_rx_byte1 == `UTM_MON_ST
						&& !lt_mode)
						nxt_mstate = M_STP; // R14
					else if (mon_rx_byte0 == `UTM_MON8_REG)
						nxt_mstate = M_RD; // R15
				end
			end
			M_STP: if (mon_tx_ready) nxt_mstate = M_IDLE;
			M_RD: nxt_mstate = M_HI;
			M_HI: if (mon_tx_ready) nxt_mstate = M_LO; // R16
			M_LO: if (mon_tx_ready) nxt_mstate = M_IDLE; // R16
			default: nxt_mstate = M_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			mstate_ff <= M_IDLE;
			mon_rx_ready_ff <= 1'b0;
			mon_tx_valid_ff <= 1'b0;
			mon_tx_byte0_ff <= 8'h00;
			mon_tx_byte1_ff <= 8'h00;
			coef_addr_ff <= 8'h00;
			rd_val_ff <= 16'h0000;
		end else begin
			mstate_ff <= nxt_mstate;
			mon_rx_ready_ff <= (nxt_mstate == M_IDLE);
			if (mstate_ff == M_IDLE && mon_take && mon_rx_byte0 == `UTM_MON8_REG)
				coef_addr_ff <= mon_rx_byte1; // R15
			// value captured once so both halves belong to the same sample
			if (mstate_ff == M_RD)
				rd_val_ff <= coef_rd_data;
			mon_tx_valid_ff <= (nxt_mstate == M_STP) || (nxt_mstate == M_HI)
				|| (nxt_mstate == M_LO);
			case (nxt_mstate)
				M_STP: begin
					mon_tx_byte0_ff <= `UTM_MON1_HDR;
					mon_tx_byte1_ff <= `UTM_MON_STP; // R14
				end
				M_HI: begin
					mon_tx_byte0_ff <= `UTM_MON8_REPLY; // R17
					mon_tx_byte1_ff <= (mstate_ff == M_RD) ? coef_rd_data[15:8]
						: rd_val_ff[15:8]; // R16
				end
				M_LO: begin
					mon_tx_byte0_ff <= `UTM_MON8_REPLY; // R17
					mon_tx_byte1_ff <= rd_val_ff[7:0]; // R16
				end
				default: begin
					mon_tx_byte0_ff <= 8'h00;
					mon_tx_byte1_ff <= 8'h00;
				end
			endcase
		end
	end
endmodule

/* File: tb/utm_ctrl_monitor.sv */
`timescale 1ns/1ns
// ********
// mode checker
// ********
module utm_ctrl_monitor (
	// clock, reset, straps
	input wire clk,
	input wire reset_n,
	input wire master_reset_pin_n,
	input wire test_select_pin,
	input wire power_status_pin,
	input wire lt_mode,
	// c/i and modes
	input wire ci_rx_valid,
	input wire [3:0] ci_rx_code,
	input wire [3:0] ci_tx_code_ff,
	input wire force_transparent_ff,
	input wire activation_inhibit_ff,
	input wire tx_enable_ff,
	input wire tx_scrambled_ff,
	input wire coef_clear_ff,
	input wire supply_disable_output_ff,
	input wire pulse_pos_ff,
	// monitor channel
	input wire mon_rx_valid,
	input wire [7:0] mon_rx_byte0,
	input wire [7:0] mon_rx_byte1,
	input wire mon_rx_ready_ff,
	input wire mon_tx_valid_ff,
	input wire [7:0] mon_tx_byte0_ff,
	input wire [7:0] mon_tx_byte1_ff,
	input wire mon_tx_ready,
	input wire [7:0] coef_addr_ff,
	input wire [15:0] coef_rd_data
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	// software modes only count with straps at 10 and no power fault
	wire sw_ok = master_reset_pin_n && !test_select_pin && !(lt_mode && power_status_pin);
	wire take = mon_rx_valid && mon_rx_ready_ff;
	chk_ssp_ind: assert property (activation_inhibit_ff && !tx_enable_ff && !coef_clear_ff
		|-> ci_tx_code_ff == (lt_mode ? 4'hf : 4'h0)) else $error("ssp indication wrong");
	chk_test_ind: assert property (coef_clear_ff && !lt_mode |-> ci_tx_code_ff == 4'h0)
		else $error("test indication wrong");
	chk_ltd_supply: assert property (supply_disable_output_ff
		|-> coef_clear_ff && ci_tx_code_ff == 4'hf) else $error("supply disable wrong");
	chk_dt_outputs: assert property (force_transparent_ff
		|-> tx_enable_ff && tx_scrambled_ff && activation_inhibit_ff) else $error("dt wrong");
	chk_test_quiet: assert property (coef_clear_ff
		|-> activation_inhibit_ff && !tx_enable_ff && !pulse_pos_ff) else $error("test wrong");
	chk_strap_dt: assert property ((!master_reset_pin_n && test_select_pin)[*3]
		|=> force_transparent_ff) else $error("strap dt late");
	chk_ci_ssp: assert property (sw_ok[*4] ##0 (ci_rx_valid && ci_rx_code == 4'h5)
		##1 !ci_rx_valid |=> activation_inhibit_ff && !tx_enable_ff) else $error("ssp late");
	chk_self_test: assert property (take && !lt_mode && mon_rx_byte0 == 8'h10
		&& mon_rx_byte1 == 8'h02 |=> mon_tx_valid_ff && mon_tx_byte1_ff == 8'h03)
		else $error("no self-test reply");
	chk_reg_reply: assert property (take && mon_rx_byte0 == 8'h88
		|=> coef_addr_ff == $past(mon_rx_byte1) ##1 mon_tx_valid_ff
		&& mon_tx_byte0_ff == 8'h80 && mon_tx_byte1_ff == coef_rd_data[15:8])
		else $error("register reply wrong");
	chk_reply_hold: assert property (mon_tx_valid_ff && !mon_tx_ready
		|=> mon_tx_valid_ff && $stable(mon_tx_byte1_ff)) else $error("reply dropped");
	cover property (take && mon_rx_byte0 == 8'h88);
	cover property (supply_disable_output_ff);
	cover property (force_transparent_ff && master_reset_pin_n);
endmodule
bind utm_ctrl utm_ctrl_monitor u_utm_ctrl_monitor (.clk, .reset_n, .master_reset_pin_n,
	.test_select_pin, .power_status_pin, .lt_mode, .ci_rx_valid, .ci_rx_code, .ci_tx_code_ff,
	.force_transparent_ff, .activation_inhibit_ff, .tx_enable_ff, .tx_scrambled_ff,
	.coef_clear_ff, .supply_disable_output_ff, .pulse_pos_ff, .mon_rx_valid, .mon_rx_byte0,
	.mon_rx_byte1, .mon_rx_ready_ff, .mon_tx_valid_ff, .mon_tx_byte0_ff, .mon_tx_byte1_ff,
	.mon_tx_ready, .coef_addr_ff, .coef_rd_data);

/* File: tb/utm_host.sv */
`timescale 1ns/1ns
// ********
// layer-1 controller model
// ********
module utm_host (
	// clock and pacing
	input wire clk,
	input wire slow,
	// replies and coefficient store
	input wire mon_tx_valid_ff,
	input wire [7:0] mon_tx_byte0_ff,
	input wire [7:0] mon_tx_byte1_ff,
	input wire [7:0] coef_addr_ff,
	output reg mon_tx_ready,
	output wire [15:0] coef_rd_data,
	output reg [31:0] replies,
	output reg [3:0] n_rep
);
	initial mon_tx_ready = 1'b1;
	initial replies = 32'h0;
	initial n_rep = 4'h0;
	// halves differ so a swapped byte order shows
	assign coef_rd_data = {coef_addr_ff ^ 8'ha5, coef_addr_ff};
	// slow mode toggles ready every cycle, stretching replies that arrive while ready is low
	always @(posedge clk) begin
		if (mon_tx_valid_ff && mon_tx_ready) begin
			replies <= {replies[15:0], mon_tx_byte0_ff, mon_tx_byte1_ff};
			n_rep <= n_rep + 4'h1;
		end
		mon_tx_ready <= #1 slow ? ~mon_tx_ready : 1'b1;
	end
endmodule

/* File: tb/test_u_transceiver_test_mode_control.sv */
`timescale 1ns/1ns
module test_u_transceiver_test_mode_control;
	// ********
	// signals
	// ********
	reg clk = 1'b0, reset_n = 1'b0, master_reset_pin_n = 1'b1, test_select_pin = 1'b0;
	reg power_status_pin = 1'b0, lt_mode = 1'b1, ci_rx_valid = 1'b0, mon_rx_valid = 1'b0;
	reg slow = 1'b0;
	reg [3:0] ci_rx_code = 4'h0, act_ind_code = 4'h9;
	reg [7:0] mon_rx_byte0 = 8'h00, mon_rx_byte1 = 8'h00;
	wire [3:0] ci_tx_code_ff, n_rep;
	wire force_transparent_ff, activation_inhibit_ff, tx_enable_ff, tx_scrambled_ff;
	wire coef_clear_ff, analog_loopback_ff, supply_disable_output_ff, pulse_pos_ff, pulse_neg_ff;
	wire mon_rx_ready_ff, mon_tx_valid_ff, mon_tx_ready;
	wire [7:0] mon_tx_byte0_ff, mon_tx_byte1_ff, coef_addr_ff;
	wire [15:0] coef_rd_data;
	wire [31:0] replies;
	int err_count = 0, checks = 0;
	// straps, c/i valid, code, {transparent,inhibit,tx,clear,disable}, indication
	logic [15:0] rows [8] = '{16'hc08f, 16'h41c9, 16'h00af, 16'haa8f, 16'hadc9, 16'ha2af,
		16'ha6bf, 16'ha449};
	always #20 clk = ~clk;
	utm_ctrl #(.PULSE_GAP_CYC(1000)) u_utm_ctrl (.clk, .reset_n, .master_reset_pin_n,
		.test_select_pin, .power_status_pin, .lt_mode, .ci_rx_valid, .ci_rx_code, .act_ind_code,
		.ci_tx_code_ff, .force_transparent_ff, .activation_inhibit_ff, .tx_enable_ff,
		.tx_scrambled_ff, .coef_clear_ff, .analog_loopback_ff, .supply_disable_output_ff,
		.pulse_pos_ff, .pulse_neg_ff, .mon_rx_valid, .mon_rx_byte0, .mon_rx_byte1,
		.mon_rx_ready_ff, .mon_tx_valid_ff, .mon_tx_byte0_ff, .mon_tx_byte1_ff, .mon_tx_ready,
		.coef_addr_ff, .coef_rd_data);
	utm_host u_utm_host (.clk, .slow, .mon_tx_valid_ff, .mon_tx_byte0_ff, .mon_tx_byte1_ff,
		.coef_addr_ff, .mon_tx_ready, .coef_rd_data, .replies, .n_rep);
	// ********
	// tasks
	// ********
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task ci(input [3:0] c);
		ci_rx_code = c;
		ci_rx_valid = 1'b1;
		tick(1);
		ci_rx_valid = 1'b0;
		tick(4);
	endtask
	// one message per idle port, first byte inverted once released
	task send(input [7:0] a, input [7:0] b);
		chk("rx_ready", 1, mon_rx_ready_ff);
		mon_rx_byte0 = a;
		mon_rx_byte1 = b;
		mon_rx_valid = 1'b1;
		tick(1);
		mon_rx_valid = 1'b0;
		mon_rx_byte0 = ~a;
	endtask
	task wait_rep(input [3:0] n);
		for (int i = 0; i < 60 && n_rep !== n; i++) tick(1);
		chk("replies", n, n_rep);
		if (n_rep !== n) print_verdict();
		tick(2);
	endtask
	task print_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ********
	// sequence
	// ********
	initial begin
		int np, t_last;
		reg pp, pn;
		tick(4);
		chk("reset", 6'h00, {ci_tx_code_ff, tx_enable_ff, mon_rx_ready_ff});
		reset_n = 1'b1;
		tick(4);
		for (int r = 0; r < 8; r++) begin
			{master_reset_pin_n, test_select_pin} = rows[r][15:14];
			tick(4);
			if (rows[r][13]) ci(rows[r][12:9]);
			chk("modes", rows[r][8:4], {force_transparent_ff, activation_inhibit_ff, tx_enable_ff,
				coef_clear_ff, supply_disable_output_ff});
			chk("ci_tx", rows[r][3:0], ci_tx_code_ff);
		end
		// one-cycle strap glitch must not reach the mode
		{master_reset_pin_n, test_select_pin} = 2'b00;
		tick(1);
		{master_reset_pin_n, test_select_pin} = 2'b10;
		tick(5);
		chk("glitch", 0, coef_clear_ff);
		power_status_pin = 1'b1;
		tick(5);
		chk("fault", 6'h2c, {coef_clear_ff, supply_disable_output_ff, ci_tx_code_ff});
		power_status_pin = 1'b0;
		{master_reset_pin_n, test_select_pin} = 2'b01;
		tick(5);
		ci(4'h8);
		chk("loop_on", 1, analog_loopback_ff);
		ci(4'h5);
		chk("dt_held", 1, force_transparent_ff);
		ci(4'h1);
		chk("loop_off", 0, analog_loopback_ff);
		{master_reset_pin_n, test_select_pin} = 2'b10;
		reset_n = 1'b0;
		lt_mode = 1'b0;
		tick(4);
		reset_n = 1'b1;
		tick(4);
		send(8'h10, 8'h02);
		wait_rep(1);
		chk("self_test", 16'h1003, replies[15:0]);
		slow = 1'b1;
		send(8'h88, 8'h5a);
		wait_rep(3);
		chk("coef", 32'h80ff805a, replies);
		ci(4'h5);
		chk("ssp_nt", 5'h10, {activation_inhibit_ff, ci_tx_code_ff});
		np = 0;
		pp = 1'b0;
		pn = 1'b0;
		for (int i = 0; i < 2500; i++) begin
			if ((pulse_pos_ff && !pp) || (pulse_neg_ff && !pn)) begin
				if (np > 0) chk("gap", 1000, i - t_last);
				chk("polarity", np % 2 == 0, pulse_pos_ff);
				np++;
				// first pulse rose with the mode, three edges before the loop
				t_last = (i == 0) ? -3 : i;
			end
			pp = pulse_pos_ff;
			pn = pulse_neg_ff;
			tick(1);
		end
		chk("pulses", 1, np >= 3);
		print_verdict();
	end
endmodule
